// File: slr_defines.svh
// Purpose: constants for the serdes loopback routing block
// Assumes: one clock at the serial bit rate (model), async active-high reset
// Notes:   definitions only
`ifndef SLR_DEFINES_SVH
`define SLR_DEFINES_SVH

// ==========================================================
// widths and counts
`define SLR_BYTE_W        8
`define SLR_BIT_CNT_W     3
`define SLR_BYTE_LAST     3'h7
`define SLR_RCLK_HALF     3'h3
// ==========================================================
// reset values
`define SLR_BYTE_RST      8'h00
`define SLR_CNT_RST       3'h0

`endif

// File: slr_loopback_monitor.sv
// Purpose: port checks for slr_loopback_top
// Assumes: selects reach the mode one edge on, transmit outputs one edge later, rx_clock_from_rclk two edges later
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none

module slr_loopback_monitor
  import slr_pkg::*;
(
  input wire logic      clock,
  input wire logic      reset,
  input wire logic      remote_loop_select,
  input wire logic      digital_local_loop_select,
  input wire logic      analog_local_loop_select,
  input wire logic      loss_of_signal,
  input wire logic      serial_rx_in,
  input wire slr_byte_t parallel_tx_data,
  input wire logic      serial_tx_out,
  input wire logic      retimer_uses_rclk,
  input wire slr_byte_t parallel_rx_data,
  input wire logic      parallel_rx_clock_out,
  input wire logic      rx_clock_from_rclk
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================================
  // remote: selects held over two edges, so the mode has settled
  // clock flags need three edges, since the deserializer source passes two registers
  sequence s_rem;
    (remote_loop_select && !analog_local_loop_select)[*2];
  endsequence
  sequence s_split;
    (remote_loop_select && digital_local_loop_select && !analog_local_loop_select)[*3];
  endsequence
  sequence s_dig;
    (digital_local_loop_select && !remote_loop_select && !analog_local_loop_select)[*3];
  endsequence
  sequence s_ana;
    (analog_local_loop_select && !remote_loop_select)[*3];
  endsequence
  // ==========================================================
  // routing and clock choice per mode
  property p_remote_tx;
    s_rem |=> serial_tx_out == $past(serial_rx_in);
  endproperty
  a_remote_tx: assert property (p_remote_tx) else $error("remote tx bit wrong");
  property p_remote_clk;
    s_rem |=> retimer_uses_rclk;
  endproperty
  a_remote_clk: assert property (p_remote_clk) else $error("retimer not on rclk");
  property p_split;
    s_split |=> !rx_clock_from_rclk && retimer_uses_rclk;
  endproperty
  a_split: assert property (p_split) else $error("split clocks wrong");
  property p_digital;
    s_dig |=> !rx_clock_from_rclk && !retimer_uses_rclk;
  endproperty
  a_digital: assert property (p_digital) else $error("digital clocks wrong");
  property p_analog;
    s_ana |=> rx_clock_from_rclk && !retimer_uses_rclk;
  endproperty
  a_analog: assert property (p_analog) else $error("analog clocks wrong");
  // ==========================================================
  // parallel receive side: divide by eight, byte hold, muting
  property p_div8;
    $rose(parallel_rx_clock_out) |-> parallel_rx_clock_out[*4] ##1
      !parallel_rx_clock_out[*4] ##1 parallel_rx_clock_out;
  endproperty
  a_div8: assert property (p_div8) else $error("rx clock not bit clock over 8");
  property p_stand;
    $changed(parallel_rx_data) |=> $stable(parallel_rx_data)[*7];
  endproperty
  a_stand: assert property (p_stand) else $error("rx byte changed early");
  property p_mute;
    loss_of_signal[*8] ##1 loss_of_signal |=> parallel_rx_data == 8'h00;
  endproperty
  a_mute: assert property (p_mute) else $error("rx byte not muted");
endmodule : slr_loopback_monitor

`default_nettype wire

// File: slr_loopback_top.sv
// Purpose: loopback routing between serializer, retimer, recovery and deserializer
// Assumes: clock models the high-speed bit clock; selects synchronous to it
// Notes:   high-speed clocks are modelled as select flags, not real clocks
//
// Behaviour
// - remote loop select high routes serial receive input to serial transmit output
// - remote loop retimes transmit with recovered clock, not multiplier
// - remote loop still deserializes receive input onto parallel receive bus
// - remote loop outputs recovered clock divided by eight as parallel clock
// - digital local loop feeds serializer output into receive deserializer
// - digital local loop clocks deserializer with multiplier output
// - digital local loop keeps serializing transmit data through retimer
// - loss-of-signal muting of receive bytes stays active in digital loop
// - analog local loop follows its select level one edge later, through the mode register
// - analog loop transmits serial data and feeds it into recovery input
// - analog looped stream passes recovery and deserializer to parallel bus
// - remote plus digital selects together, with analog select low, give split loopback
// - split: serializer feeds deserializer, receive input retimed onto transmit
`timescale 1ns/1ps
`default_nettype none

module slr_loopback_top
  import slr_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      reset,
  input  wire logic      remote_loop_select,
  input  wire logic      digital_local_loop_select,
  input  wire logic      analog_local_loop_select,
  input  wire logic      loss_of_signal,
  input  wire logic      serial_rx_in,
  input  wire slr_byte_t parallel_tx_data,
  output var  logic      serial_tx_out,
  output var  logic      retimer_uses_rclk,
  output var  slr_byte_t parallel_rx_data,
  output var  logic      parallel_rx_clock_out,
  output var  logic      rx_clock_from_rclk
);
  typedef struct packed {
    slr_mode_e                 mode;
    logic                      tx_bit;
    logic                      tx_rclk;
    slr_byte_t                 rx_byte;
    logic                      pclk;
    logic [`SLR_BIT_CNT_W-1:0] div;
    logic                      rx_rclk;
  } slr_top_s;

  slr_top_s st;
  slr_top_s next_st;

  slr_ser_if tx_ser ();
  slr_ser_if rx_ser ();

  slr_byte_t rx_byte_raw;
  logic      rx_byte_valid;
  logic      rx_src_rclk;
  logic      loop_to_receive_deserializer;
  logic      loop_to_tx;
  logic      cdr_bit;

  // ==========================================================
  // serializer
  slr_piso u_piso (
    .clock            (clock),
    .reset            (reset),
    .parallel_tx_data (parallel_tx_data),
    .ser              (tx_ser)
  );

  // ==========================================================
  // receive path steering
  // serializer into deserializer
  assign loop_to_receive_deserializer = (st.mode == SLR_DIGITAL) || (st.mode == SLR_SPLIT);
  assign loop_to_tx = (st.mode == SLR_REMOTE) || (st.mode == SLR_SPLIT)
                      || (st.mode == SLR_ANALOG_REMOTE);
  // transmit stream replaces receive input at recovery
  assign cdr_bit = (st.mode == SLR_ANALOG || st.mode == SLR_ANALOG_REMOTE)
                   ? tx_ser.bit_val : serial_rx_in;

  // looped stream goes through recovery then deserializer
  // receive input still deserialized in remote loop
  assign rx_ser.bit_val = loop_to_receive_deserializer ? tx_ser.bit_val : cdr_bit;
  // multiplier clock times deserializer in digital loop
  assign rx_ser.use_rclk = !loop_to_receive_deserializer;

  slr_receive_deserializer u_receive_deserializer (
    .clock        (clock),
    .reset        (reset),
    .ser          (rx_ser),
    .byte_out     (rx_byte_raw),
    .byte_valid   (rx_byte_valid),
    .clk_src_rclk (rx_src_rclk)
  );

  // ==========================================================
  // mode decode and output registers
  always_comb begin
    next_st = st;
    if (analog_local_loop_select) begin
      next_st.mode = remote_loop_select ? SLR_ANALOG_REMOTE : SLR_ANALOG;
    end else if (remote_loop_select && digital_local_loop_select) begin
      next_st.mode = SLR_SPLIT;
    end else if (remote_loop_select) begin
      next_st.mode = SLR_REMOTE;
    end else if (digital_local_loop_select) begin
      next_st.mode = SLR_DIGITAL;
    end else begin
      next_st.mode = SLR_NORMAL;
    end

    // remote, split and analog remote modes retime receive data onto transmit
    // otherwise serializer output goes out through retimer
    next_st.tx_bit = loop_to_tx ? serial_rx_in : tx_ser.bit_val;
    // recovered clock to retimer in remote loop
    next_st.tx_rclk = loop_to_tx || tx_ser.use_rclk;

    // mute receive bytes on loss of signal, in every mode
    if (rx_byte_valid) begin
      next_st.rx_byte = loss_of_signal ? `SLR_BYTE_RST : rx_byte_raw;
    end

    // parallel clock is bit clock divided by eight
    next_st.div  = st.div + 3'h1;
    next_st.pclk = (st.div >= `SLR_RCLK_HALF) && (st.div != `SLR_BYTE_LAST);
    next_st.rx_rclk = rx_src_rclk;
  end

  // state register; async reset loads constants only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '{mode: SLR_NORMAL, tx_bit: 1'b0, tx_rclk: 1'b0,
              rx_byte: `SLR_BYTE_RST, pclk: 1'b0, div: `SLR_CNT_RST,
              rx_rclk: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign serial_tx_out         = st.tx_bit;
  assign retimer_uses_rclk     = st.tx_rclk;
  assign parallel_rx_data      = st.rx_byte;
  assign parallel_rx_clock_out = st.pclk;
  assign rx_clock_from_rclk    = st.rx_rclk;
endmodule : slr_loopback_top

`default_nettype wire

// File: slr_optic_model.sv
// Purpose: optical module stand-in on the serial side
// Assumes: one bit per bit clock, msb first
// Notes:   stream runs free, so no idle level is modelled
`timescale 1ns/1ps
`default_nettype none

module slr_optic_model (
  input  wire logic       clock,
  input  wire logic [7:0] pattern,
  input  wire logic       serial_tx_out,
  output var  logic       serial_rx_in,
  output var  logic [7:0] tx_seen
);
  logic [2:0] bit_idx = 3'h0;
  // source bits change off the sampling edge
  initial serial_rx_in = 1'b0;
  always @(negedge clock) begin
    serial_rx_in <= pattern[3'h7 - bit_idx];
    bit_idx      <= bit_idx + 3'h1;
  end
  // keep the last eight transmitted bits, sampled once settled
  always @(negedge clock) begin
    tx_seen <= {tx_seen[6:0], serial_tx_out};
  end
endmodule : slr_optic_model

`default_nettype wire

// File: slr_piso.sv
// Purpose: parallel-to-serial converter, msb first
// Assumes: one bit per clock edge, byte loaded every 8 edges
// Notes:   drives the serial source side of slr_ser_if
`timescale 1ns/1ps
`default_nettype none

module slr_piso
  import slr_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      reset,
  input  wire slr_byte_t parallel_tx_data,
  slr_ser_if.src         ser
);
  typedef struct packed {
    slr_byte_t                 shift;
    logic [`SLR_BIT_CNT_W-1:0] cnt;
  } slr_piso_s;

  slr_piso_s st;
  slr_piso_s next_st;

  // ==========================================================
  // shift out msb first, reload after the eighth bit
  always_comb begin
    next_st = st;
    next_st.cnt = st.cnt + 3'h1;
    if (st.cnt == `SLR_BYTE_LAST) begin
      next_st.shift = parallel_tx_data;
    end else begin
      next_st.shift = {st.shift[`SLR_BYTE_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '{shift: `SLR_BYTE_RST, cnt: `SLR_CNT_RST};
    end else begin
      st <= next_st;
    end
  end

  assign ser.bit_val  = st.shift[`SLR_BYTE_W-1];
  assign ser.use_rclk = 1'b0; // transmit data always timed by the multiplier
endmodule : slr_piso

`default_nettype wire

// File: slr_pkg.sv
// Purpose: types shared by the loopback routing modules
// Assumes: slr_defines.svh gives the widths
// Notes:   mode enum resolves the three selects
`include "slr_defines.svh"

package slr_pkg;
  // ==========================================================
  // loopback modes
  typedef enum logic [2:0] {
    SLR_NORMAL,
    SLR_REMOTE,
    SLR_DIGITAL,
    SLR_ANALOG,
    SLR_SPLIT,
    SLR_ANALOG_REMOTE
  } slr_mode_e;

  typedef logic [`SLR_BYTE_W-1:0] slr_byte_t;
endpackage : slr_pkg

// File: slr_receive_deserializer.sv
// Purpose: receive deserializer, shifts bits in and presents bytes
// Assumes: framing fixed to a 3-bit counter from reset
// Notes:   byte_valid pulses when a full byte is assembled
`timescale 1ns/1ps
`default_nettype none

module slr_receive_deserializer
  import slr_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      reset,
  slr_ser_if.dst         ser,
  output var  slr_byte_t byte_out,
  output var  logic      byte_valid,
  output var  logic      clk_src_rclk
);
  typedef struct packed {
    slr_byte_t                 shift;
    logic [`SLR_BIT_CNT_W-1:0] cnt;
    slr_byte_t                 byte_q;
    logic                      valid;
    logic                      src;
  } slr_receive_deserializer_s;

  slr_receive_deserializer_s st;
  slr_receive_deserializer_s next_st;

  // ==========================================================
  // shift in, capture on the eighth bit
  always_comb begin
    next_st = st;
    next_st.shift = {st.shift[`SLR_BYTE_W-2:0], ser.bit_val};
    next_st.cnt   = st.cnt + 3'h1;
    next_st.valid = (st.cnt == `SLR_BYTE_LAST);
    next_st.src   = ser.use_rclk;
    if (st.cnt == `SLR_BYTE_LAST) begin
      next_st.byte_q = {st.shift[`SLR_BYTE_W-2:0], ser.bit_val};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '{shift: `SLR_BYTE_RST, cnt: `SLR_CNT_RST, byte_q: `SLR_BYTE_RST,
              valid: 1'b0, src: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign byte_out     = st.byte_q;
  assign byte_valid   = st.valid;
  assign clk_src_rclk = st.src;
endmodule : slr_receive_deserializer

`default_nettype wire

// File: slr_ser_if.sv
// Purpose: serial bit stream with its clock select between routing modules
// Assumes: single clock domain
// Notes:   use_rclk marks which high-speed clock times the bit
`timescale 1ns/1ps
`default_nettype none

interface slr_ser_if;
  logic bit_val;    // serial bit
  logic use_rclk;   // high = recovered clock, low = multiplier clock
  modport src (output bit_val, output use_rclk);
  modport dst (input bit_val, input use_rclk);
endinterface : slr_ser_if

`default_nettype wire

// File: tb_serdes_loopback_routing.sv
// Purpose: random and corner tests of every select combination
// Assumes: bytes held long enough for the free byte counter to wrap
// Notes:   byte framing is free, so bytes are compared up to rotation
`timescale 1ns/1ps
`default_nettype none

module tb_serdes_loopback_routing;
  import slr_pkg::*;
  logic clock = 1'b0, reset = 1'b1, loss_of_signal = 1'b0;
  logic remote_loop_select = 1'b0, digital_local_loop_select = 1'b0;
  logic analog_local_loop_select = 1'b0;
  slr_byte_t parallel_tx_data = 8'h00, parallel_rx_data;
  logic [7:0] pattern = 8'h00, tx_seen;
  logic serial_rx_in, serial_tx_out, retimer_uses_rclk, parallel_rx_clock_out, rx_clock_from_rclk;
  int mismatches = 0, num_checks = 0;

  always #50 clock = ~clock;
  slr_loopback_top dut (.clock, .reset, .remote_loop_select, .digital_local_loop_select,
    .analog_local_loop_select, .loss_of_signal, .serial_rx_in, .parallel_tx_data,
    .serial_tx_out, .retimer_uses_rclk, .parallel_rx_data, .parallel_rx_clock_out,
    .rx_clock_from_rclk);
  slr_optic_model u_optic (.clock, .pattern, .serial_tx_out, .serial_rx_in, .tx_seen);

  // ==========================================================
  // compare, rotation test, verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] is_rot(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] d;
    d = {b, b};
    for (int k = 0; k < 8; k++) if (d[k +: 8] === a) return 8'h01;
    return 8'h00;
  endfunction : is_rot
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // every select combination, corner bytes first, then random
  initial begin
    logic [2:0] sel;
    int n;
    void'($urandom(32'h0D9C7BF2));
    repeat (10) @(negedge clock);
    chk("rst_rclk_flag", 8'h01, {7'h0, rx_clock_from_rclk});
    repeat (6) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sel = 3'(i);
      {analog_local_loop_select, digital_local_loop_select, remote_loop_select} = sel;
      parallel_tx_data = (i < 8) ? 8'h01 : 8'($urandom_range(1, 254));
      // weight other than 4 keeps the two streams apart under rotation
      if ($countones(parallel_tx_data) inside {0, 4, 8}) parallel_tx_data[0] = 1'b1;
      if ($countones(parallel_tx_data) == 4) parallel_tx_data[1] = ~parallel_tx_data[1];
      pattern = ~parallel_tx_data;
      repeat (40) @(negedge clock);
      n = 0;
      while (parallel_rx_clock_out !== 1'b1 && n < 20) begin
        @(negedge clock);
        n++;
      end
      if (n >= 20) begin
        mismatches++;
        $display("mismatch rx_clock expected 1 seen %b", parallel_rx_clock_out);
        print_verdict();
      end
      if (!(sel[2] & sel[0])) begin
        chk("rx_byte", 8'h01, is_rot(sel[2] | sel[1] ? parallel_tx_data : pattern,
          parallel_rx_data));
        chk("tx_bits", 8'h01, is_rot(sel[0] ? pattern : parallel_tx_data, tx_seen));
        chk("retimer", {7'h0, sel[0]}, {7'h0, retimer_uses_rclk});
      end
      chk("rx_clk_src", {7'h0, !(sel[1] & !sel[2])}, {7'h0, rx_clock_from_rclk});
      loss_of_signal = 1'b1;
      repeat (20) @(negedge clock);
      chk("rx_mute", 8'h00, parallel_rx_data);
      loss_of_signal = 1'b0;
    end
    print_verdict();
  end
endmodule : tb_serdes_loopback_routing

bind slr_loopback_top slr_loopback_monitor u_mon (.clock, .reset, .remote_loop_select,
  .digital_local_loop_select, .analog_local_loop_select, .loss_of_signal, .serial_rx_in,
  .parallel_tx_data, .serial_tx_out, .retimer_uses_rclk, .parallel_rx_data,
  .parallel_rx_clock_out, .rx_clock_from_rclk);

`default_nettype wire
